// ### src/aux_seq_ctrl.sv
// auxiliary converter sequencer: start modes, mux settling, conversion time
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module aux_seq_ctrl (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // avalon-mm slave
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // device status and primary converter
  input  wire logic        dev_standby,
  input  wire logic        current_conv_data_ready_n,
  // conversion datapath
  input  wire logic [1:0]  seq_last_step,
  input  wire logic        conv_data_valid,
  input  wire logic [15:0] conv_data,
  output logic             conv_start,
  output logic [1:0]       aux_sequence_step_counter,
  output logic             seq_busy,
  output logic [3:0]       avg_ratio,
  output logic [9:0]       oversampling_ratio,
  output logic [15:0]      conv_result
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_CONV} seq_phase_e;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [1:0]  mode;
    logic [2:0]  dly;
    logic [1:0]  osr;
    logic [7:0]  scratch;
    logic        enable;
    seq_phase_e  phase;
    logic [1:0]  step;
    logic        drdy_prev;
    logic        conv_start;
    logic [15:0] result;
    logic [3:0]  avg;
    logic [9:0]  ratio;
  } seq_state_s;

  seq_state_s state_reg;
  seq_state_s state_next;

  timer_if tif ();

  cycle_timer u_timer (
    .mclk (mclk),
    .rstn (rstn),
    .t    (tif)
  );

  logic                          tmr_load;
  logic [aux_seq_pkg::TMR_W-1:0] tmr_val;
  logic [7:0]                    idx;
  logic [15:0]                   wmask;
  logic [15:0]                   cfg_word;
  logic                          wr_take;
  logic                          go_take;
  logic                          active;
  logic                          drdy_fall;
  logic                          last_step;

  assign tif.load     = tmr_load;
  assign tif.load_val = tmr_val;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // one wait state: the request is taken at the second edge after it appears
  assign waitrequest = (read || write) && !state_reg.ack;
  assign idx         = address[9:2];
  assign wr_take     = write && state_reg.ack;
  assign wmask       = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  assign active      = state_reg.enable && !dev_standby;
  assign go_take     = wr_take && (idx == aux_seq_pkg::IDX_CTRL) &&
                       byteenable[0] && writedata[aux_seq_pkg::GO_BIT];
  assign drdy_fall   = state_reg.drdy_prev && !current_conv_data_ready_n;
  assign last_step   = (state_reg.step == seq_last_step);

  always_comb begin
    cfg_word = '0;
    cfg_word[aux_seq_pkg::MODE_MSB:aux_seq_pkg::MODE_LSB] = state_reg.mode;
    cfg_word[aux_seq_pkg::DLY_MSB:aux_seq_pkg::DLY_LSB]   = state_reg.dly;
    cfg_word[aux_seq_pkg::OSR_MSB:aux_seq_pkg::OSR_LSB]   = state_reg.osr;
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [15:0] wv;
    wv         = '0;
    state_next = state_reg;
    tmr_load   = 1'b0;
    tmr_val    = aux_seq_pkg::MUX_DLY[state_reg.dly];
    state_next.ack        = (read || write) && !state_reg.ack;
    state_next.conv_start = 1'b0;
    state_next.drdy_prev  = current_conv_data_ready_n;

    // read data captured in the wait cycle, held while waitrequest is low
    if (read && !state_reg.ack) begin
      state_next.rdata = '0;
      case (idx)
        aux_seq_pkg::IDX_SEQ_CFG: state_next.rdata[15:0] = cfg_word;
        aux_seq_pkg::IDX_SCRATCH: begin
          state_next.rdata[aux_seq_pkg::SCR_MSB:aux_seq_pkg::SCR_LSB] =
            state_reg.scratch;
        end
        aux_seq_pkg::IDX_CTRL: begin
          state_next.rdata[aux_seq_pkg::EN_BIT] = state_reg.enable;
        end
        aux_seq_pkg::IDX_STATUS: begin
          state_next.rdata[aux_seq_pkg::STAT_BUSY_BIT] =
            (state_reg.phase != ST_IDLE);
          state_next.rdata[aux_seq_pkg::STAT_SET_BIT] =
            (state_reg.phase == ST_SETTLE);
          state_next.rdata[aux_seq_pkg::STAT_STEP_MSB:
                           aux_seq_pkg::STAT_STEP_LSB] = state_reg.step;
        end
        aux_seq_pkg::IDX_RESULT: state_next.rdata[15:0] = state_reg.result;
        default: state_next.rdata = '0;
      endcase
    end

    // register writes, masked by byte enables and writable fields
    if (wr_take) begin
      case (idx)
        aux_seq_pkg::IDX_SEQ_CFG: begin
          wv = (cfg_word & ~(wmask & aux_seq_pkg::CFG_WMASK)) |
               (writedata[15:0] & wmask & aux_seq_pkg::CFG_WMASK);
          state_next.mode = wv[aux_seq_pkg::MODE_MSB:aux_seq_pkg::MODE_LSB];
          state_next.dly  = wv[aux_seq_pkg::DLY_MSB:aux_seq_pkg::DLY_LSB];
          state_next.osr  = wv[aux_seq_pkg::OSR_MSB:aux_seq_pkg::OSR_LSB];
        end
        aux_seq_pkg::IDX_SCRATCH: begin
          if (byteenable[0]) begin
            state_next.scratch = writedata[aux_seq_pkg::SCR_MSB:
                                           aux_seq_pkg::SCR_LSB];
          end
        end
        aux_seq_pkg::IDX_CTRL: begin
          if (byteenable[0]) begin
            state_next.enable = writedata[aux_seq_pkg::EN_BIT];
          end
        end
        default: state_next.enable = state_reg.enable;
      endcase
    end

    // sequencer
    case (state_reg.phase)
      ST_IDLE: begin
        if (active && !go_take && drdy_fall &&
            state_reg.mode == aux_seq_pkg::MODE_DRDY) begin
          state_next.phase = ST_SETTLE;
          state_next.step  = aux_seq_pkg::STEP_FIRST;
          tmr_load         = 1'b1;
        end
      end
      ST_SETTLE: begin
        if (tif.expire) begin
          state_next.phase      = ST_CONV;
          state_next.conv_start = 1'b1;
          tmr_load              = 1'b1;
          tmr_val = aux_seq_pkg::CONV_T[state_reg.osr];
        end
      end
      ST_CONV: begin
        // data-ready edges are not looked at here, so they cannot restart
        if (tif.expire) begin
          if (!last_step) begin
            state_next.phase = ST_SETTLE;
            state_next.step  = state_reg.step + 2'h1;
            tmr_load         = 1'b1;
          end else if (state_reg.mode[aux_seq_pkg::CONT_BIT]) begin
            state_next.phase = ST_SETTLE;
            state_next.step  = aux_seq_pkg::STEP_FIRST;
            tmr_load         = 1'b1;
          end else begin
            state_next.phase = ST_IDLE;
          end
        end
      end
      default: state_next.phase = ST_IDLE;
    endcase

    // go bit wins over everything the sequencer was doing
    if (go_take && active) begin
      state_next.phase      = ST_SETTLE;
      state_next.step       = aux_seq_pkg::STEP_FIRST;
      state_next.conv_start = 1'b0;
      tmr_load              = 1'b1;
      tmr_val = aux_seq_pkg::MUX_DLY[state_reg.dly];
    end

    if (conv_data_valid && active) begin
      state_next.result = conv_data;
    end

    // disabled or standby: phase, step, result and conv_start back to the start
    if (!state_next.enable || dev_standby) begin
      state_next.phase      = ST_IDLE;
      state_next.step       = aux_seq_pkg::STEP_FIRST;
      state_next.result     = aux_seq_pkg::RESULT_CLR;
      state_next.conv_start = 1'b0;
    end

    state_next.avg   = aux_seq_pkg::AVG_ONE << state_next.osr;
    state_next.ratio = aux_seq_pkg::SINC3_RATIO << state_next.osr;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg           <= '0;
      state_reg.mode      <= aux_seq_pkg::MODE_RST;
      state_reg.dly       <= aux_seq_pkg::DLY_RST;
      state_reg.osr       <= aux_seq_pkg::OSR_RST;
      state_reg.scratch   <= aux_seq_pkg::SCR_RST;
      state_reg.enable    <= aux_seq_pkg::EN_RST;
      state_reg.phase     <= ST_IDLE;
      state_reg.drdy_prev <= 1'b1;
      state_reg.avg       <= aux_seq_pkg::AVG_ONE;
      state_reg.ratio     <= aux_seq_pkg::SINC3_RATIO;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign readdata                  = state_reg.rdata;
  assign conv_start                = state_reg.conv_start;
  assign aux_sequence_step_counter = state_reg.step;
  assign seq_busy                  = (state_reg.phase != ST_IDLE);
  assign avg_ratio                 = state_reg.avg;
  assign oversampling_ratio        = state_reg.ratio;
  assign conv_result               = state_reg.result;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // cycles since the last timer load and cycles spent converting; counters
  // stand in for long repetitions, which the property engines unroll
  logic [aux_seq_pkg::TMR_W-1:0] conv_cyc;
  logic [aux_seq_pkg::TMR_W-1:0] settle_cyc;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      conv_cyc   <= '0;
      settle_cyc <= '0;
    end else begin
      settle_cyc <= tmr_load ? '0 : settle_cyc + 1'b1;
      conv_cyc   <= (state_reg.phase != ST_CONV) ? '0 : conv_cyc + 1'b1;
    end
  end

  a_once_stops: assert property (
    @(posedge mclk) disable iff (!rstn)
    (state_reg.phase == ST_CONV && tif.expire && last_step &&
     state_reg.mode == aux_seq_pkg::MODE_ONCE && !go_take)
    |=> (state_reg.phase == ST_IDLE) && !conv_start)
    else $error("single-shot sequence did not stop");

  a_go_restart: assert property (
    @(posedge mclk) disable iff (!rstn)
    (go_take && active && state_next.enable)
    |=> (state_reg.phase == ST_SETTLE) && (state_reg.step == 2'h0)
        ##1 (state_reg.phase == ST_SETTLE))
    else $error("go bit did not restart sequence");

  a_drdy_start: assert property (
    @(posedge mclk) disable iff (!rstn)
    (state_reg.phase == ST_IDLE && active && state_next.enable &&
     state_reg.mode == aux_seq_pkg::MODE_DRDY &&
     $fell(current_conv_data_ready_n))
    |=> state_reg.phase == ST_SETTLE)
    else $error("data-ready edge did not start sequence");

  a_drdy_ignored: assert property (
    @(posedge mclk) disable iff (!rstn)
    (state_reg.phase == ST_CONV && !tif.expire && !go_take && active &&
     state_next.enable && $fell(current_conv_data_ready_n))
    |=> (state_reg.phase == ST_CONV) && $stable(state_reg.step))
    else $error("data-ready edge disturbed running sequence");

  a_cont_repeat: assert property (
    @(posedge mclk) disable iff (!rstn)
    (state_reg.phase == ST_CONV && tif.expire && last_step && active &&
     state_next.enable && state_reg.mode[aux_seq_pkg::CONT_BIT])
    |=> (state_reg.phase == ST_SETTLE) && (state_reg.step == 2'h0))
    else $error("continuous sequence did not repeat");

  a_settle_time: assert property (
    @(posedge mclk) disable iff (!rstn)
    (state_reg.phase == ST_SETTLE && tif.expire)
    |-> (settle_cyc + 1'b1 == aux_seq_pkg::MUX_DLY[state_reg.dly]))
    else $error("mux settling time wrong");

  a_osr_ratio: assert property (
    @(posedge mclk) disable iff (!rstn)
    (oversampling_ratio == (aux_seq_pkg::SINC3_RATIO * avg_ratio)) &&
    (avg_ratio == (4'h1 << state_reg.osr)))
    else $error("oversampling ratio inconsistent");

  a_conv_time: assert property (
    @(posedge mclk) disable iff (!rstn)
    (state_reg.phase == ST_CONV && tif.expire)
    |-> (conv_cyc + 1'b1 == aux_seq_pkg::CONV_T[state_reg.osr]))
    else $error("conversion time wrong");

  a_scratch_rw: assert property (
    @(posedge mclk) disable iff (!rstn)
    (wr_take && idx == aux_seq_pkg::IDX_SCRATCH && byteenable[0])
    |=> state_reg.scratch == $past(writedata[7:0]))
    else $error("scratch write lost");

  a_off_clears: assert property (
    @(posedge mclk) disable iff (!rstn)
    (dev_standby || !state_reg.enable)
    |=> (conv_result == 16'h0000) && (aux_sequence_step_counter == 2'h0)
        && !seq_busy)
    else $error("disable did not clear result and step");

  a_resv_zero: assert property (
    @(posedge mclk) disable iff (!rstn)
    (read && !waitrequest && idx == aux_seq_pkg::IDX_SEQ_CFG)
    |-> (readdata & ~{16'h0000, aux_seq_pkg::CFG_WMASK}) == 32'h00000000)
    else $error("reserved bits read non-zero");

endmodule

// ### src/aux_seq_pkg.sv
// constants for the auxiliary converter sequencer and its register block
package aux_seq_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_SEQ_CFG = 8'h8C;
  localparam logic [7:0] IDX_SCRATCH = 8'h8D;
  localparam logic [7:0] IDX_CTRL    = 8'hA0;
  localparam logic [7:0] IDX_STATUS  = 8'hA1;
  localparam logic [7:0] IDX_RESULT  = 8'hA2;

  // ----------------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------------
  localparam int MODE_MSB = 15;
  localparam int MODE_LSB = 14;
  localparam int DLY_MSB  = 10;
  localparam int DLY_LSB  = 8;
  localparam int OSR_MSB  = 1;
  localparam int OSR_LSB  = 0;
  localparam int SCR_MSB  = 7;
  localparam int SCR_LSB  = 0;
  localparam logic [15:0] CFG_WMASK = 16'hC703;
  localparam logic [15:0] SCR_WMASK = 16'h00FF;
  localparam logic [1:0]  MODE_RST  = 2'h0;
  localparam logic [2:0]  DLY_RST   = 3'h0;
  localparam logic [1:0]  OSR_RST   = 2'h0;
  localparam logic [7:0]  SCR_RST   = 8'h00;
  localparam int GO_BIT   = 0;
  localparam int EN_BIT   = 1;
  localparam logic EN_RST = 1'b1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_SET_BIT   = 1;
  localparam int STAT_STEP_LSB  = 4;
  localparam int STAT_STEP_MSB  = 5;
  localparam logic [15:0] RESULT_CLR = 16'h0000;
  localparam logic [1:0]  STEP_FIRST = 2'h0;

  // ----------------------------------------------------------------------
  // modes and timing (counts in master clock periods)
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_ONCE = 2'h0;
  localparam logic [1:0] MODE_DRDY = 2'h1;
  localparam int CONT_BIT = 1;
  localparam int TMR_W    = 13;
  localparam logic [TMR_W-1:0] MUX_DLY [8] = '{
    13'h0010, 13'h0040, 13'h0080, 13'h0100,
    13'h0200, 13'h0400, 13'h0800, 13'h1000};
  localparam logic [TMR_W-1:0] CONV_T [4] = '{
    13'h0180, 13'h0200, 13'h0300, 13'h0500};
  localparam logic [9:0] SINC3_RATIO = 10'h040;
  localparam logic [3:0] AVG_ONE     = 4'h1;

endpackage

// ### src/timer_if.sv
// load/expire handshake between the sequencer and its cycle timer
`timescale 1ns/1ps
interface timer_if;
  logic                         load;
  logic [aux_seq_pkg::TMR_W-1:0] load_val;
  logic                         expire;
  modport ctl (output load, output load_val, input expire);
  modport tmr (input load, input load_val, output expire);
endinterface

// ### src/cycle_timer.sv
// down-counter that expires a given number of cycles after a load
`timescale 1ns/1ps
module cycle_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // load and expiry
  timer_if.tmr     t
);

  typedef struct packed {
    logic                          running;
    logic [aux_seq_pkg::TMR_W-1:0] cnt;
  } timer_state_s;

  timer_state_s state_reg;
  timer_state_s state_next;

  // load in cycle c gives expire in cycle c + load_val
  assign t.expire = state_reg.running && (state_reg.cnt == '0);

  always_comb begin
    state_next = state_reg;
    if (t.load) begin
      state_next.running = 1'b1;
      state_next.cnt     = t.load_val - 1'b1;
    end else if (t.expire) begin
      state_next.running = 1'b0;
    end else if (state_reg.running) begin
      state_next.cnt = state_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// ### sim/testbench.sv
// self-checking bench for the auxiliary converter sequencer
`timescale 1ns/1ps
module testbench;
  // --------------------------------------------------------------------
  // stimulus, observed outputs and bookkeeping
  // --------------------------------------------------------------------
  logic        mclk         = 1'b0;
  logic        rstn         = 1'b0;
  logic [9:0]  address      = 10'h000;
  logic        read         = 1'b0;
  logic        write        = 1'b0;
  logic [31:0] writedata    = 32'h00000000;
  logic [3:0]  lanes        = 4'hF;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        dev_standby  = 1'b0;
  logic        drdy_n       = 1'b1;
  logic [1:0]  last_step    = 2'h0;
  logic        dvalid       = 1'b0;
  logic [15:0] ddata        = 16'h0000;
  logic        conv_start;
  logic [1:0]  step;
  logic        seq_busy;
  logic [3:0]  avg_ratio;
  logic [9:0]  osr_ratio;
  logic [15:0] conv_result;
  int          err_count       = 0;
  int          samples_checked = 0;
  int          cycles          = 0;
  int          mux_n [8] = '{16, 64, 128, 256, 512, 1024, 2048, 4096};
  int          conv_t [4] = '{384, 512, 768, 1280};

  aux_seq_ctrl aux_seq_ctrl_inst (
    .mclk(mclk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(lanes),
    .readdata(readdata), .waitrequest(waitrequest),
    .dev_standby(dev_standby), .current_conv_data_ready_n(drdy_n),
    .seq_last_step(last_step), .conv_data_valid(dvalid),
    .conv_data(ddata), .conv_start(conv_start),
    .aux_sequence_step_counter(step), .seq_busy(seq_busy),
    .avg_ratio(avg_ratio), .oversampling_ratio(osr_ratio),
    .conv_result(conv_result));

  always #20 mclk = ~mclk;

  // hang guard: the whole run needs well under this many cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      test_done();
    end
  end

  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task automatic test_done();
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input int n, input int lo, input int hi);
    samples_checked++;
    if (n < lo || n > hi) begin
      err_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h..%0h", $time, n, lo, hi);
    end
  endtask

  // waitrequest is read before the edge's own updates land
  task automatic bus_wr(input logic [7:0] idx, input logic [15:0] d);
    @(posedge mclk);
    address   <= {idx, 2'b00};
    writedata <= {16'h0000, d};
    write     <= 1'b1;
    @(posedge mclk);
    while (waitrequest !== 1'b0) @(posedge mclk);
    write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp);
    int w;
    w = 0;
    @(posedge mclk);
    address <= {idx, 2'b00};
    read    <= 1'b1;
    @(posedge mclk);
    while (waitrequest !== 1'b0) begin
      @(posedge mclk);
      w++;
    end
    check(readdata, {16'h0000, exp});
    check(w, 1);
    read <= 1'b0;
  endtask

  // configuration is only touched while the converter is off
  task automatic cfg(input logic [1:0] m, input logic [2:0] dl,
                     input logic [1:0] os);
    bus_wr(aux_seq_pkg::IDX_CTRL, 16'h0000);
    bus_wr(aux_seq_pkg::IDX_SEQ_CFG, {m, 3'h0, dl, 6'h00, os});
    bus_wr(aux_seq_pkg::IDX_CTRL, 16'h0002);
  endtask

  task automatic go();
    bus_wr(aux_seq_pkg::IDX_CTRL, 16'h0003);
  endtask

  task automatic wait_cs(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (conv_start !== 1'b1 && n < 6000);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (seq_busy !== 1'b0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    check(seq_busy, 1'b0);
  endtask

  task automatic pulse_valid(input logic [15:0] d);
    ddata  <= d;
    dvalid <= 1'b1;
    @(posedge mclk);
    dvalid <= 1'b0;
  endtask

  task automatic drdy_fall();
    @(posedge mclk);
    drdy_n <= 1'b0;
    @(posedge mclk);
    drdy_n <= 1'b1;
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_regs();
    check(osr_ratio, 32'h40);
    rd_chk(aux_seq_pkg::IDX_SEQ_CFG, 16'h0000);
    rd_chk(aux_seq_pkg::IDX_SCRATCH, 16'h0000);
    bus_wr(aux_seq_pkg::IDX_CTRL, 16'h0000);
    bus_wr(aux_seq_pkg::IDX_SEQ_CFG, 16'hFFFF);
    rd_chk(aux_seq_pkg::IDX_SEQ_CFG, 16'hC703);
    bus_wr(aux_seq_pkg::IDX_SEQ_CFG, 16'h0000);
    bus_wr(aux_seq_pkg::IDX_SCRATCH, 16'hFFFF);
    rd_chk(aux_seq_pkg::IDX_SCRATCH, 16'h00FF);
    // only the upper lane is enabled, so the spare byte must survive
    lanes <= 4'h2;
    bus_wr(aux_seq_pkg::IDX_SCRATCH, 16'h0000);
    lanes <= 4'hF;
    rd_chk(aux_seq_pkg::IDX_SCRATCH, 16'h00FF);
    bus_wr(aux_seq_pkg::IDX_SCRATCH, 16'h005A);
    rd_chk(aux_seq_pkg::IDX_SCRATCH, 16'h005A);
    rd_chk(8'h8E, 16'h0000);
  endtask

  task automatic t_delay();
    int n;
    for (int k = 0; k < 8; k++) begin
      cfg(aux_seq_pkg::MODE_ONCE, 3'(k), 2'h0);
      last_step <= 2'h0;
      go();
      wait_cs(n);
      chk_in(n, mux_n[k], mux_n[k] + 3);
      wait_idle();
    end
  endtask

  task automatic t_osr();
    int n;
    int c;
    for (int k = 0; k < 4; k++) begin
      cfg(aux_seq_pkg::MODE_ONCE, 3'h0, 2'(k));
      check(osr_ratio, 32'h40 << k);
      check(avg_ratio, 32'h1 << k);
      last_step <= 2'h1;
      go();
      wait_cs(n);
      pulse_valid(16'h1230 + 16'(k));
      wait_cs(n);
      chk_in(n + 1, conv_t[k] + 16, conv_t[k] + 19);
      check(step, 2'h1);
      wait_idle();
      c = 0;
      repeat (300) begin
        @(posedge mclk);
        if (conv_start === 1'b1) c++;
      end
      check(c, 0);
      check(conv_result, 16'h1230 + 16'(k));
    end
  endtask

  task automatic t_abort();
    int n;
    cfg(aux_seq_pkg::MODE_ONCE, 3'h0, 2'h0);
    last_step <= 2'h1;
    go();
    wait_cs(n);
    wait_cs(n);
    repeat (50) @(posedge mclk);
    go();
    @(posedge mclk);
    check(step, 2'h0);
    check(seq_busy, 1'b1);
    wait_cs(n);
    chk_in(n + 1, 16, 19);
    check(step, 2'h0);
    wait_idle();
  endtask

  task automatic t_drdy();
    int n;
    cfg(aux_seq_pkg::MODE_DRDY, 3'h0, 2'h0);
    last_step <= 2'h1;
    drdy_fall();
    wait_cs(n);
    chk_in(n, 16, 22);
    drdy_fall();
    wait_cs(n);
    chk_in(n + 2, 400, 403);
    check(step, 2'h1);
    wait_idle();
    go();
    @(posedge mclk);
    check(seq_busy, 1'b1);
    wait_idle();
  endtask

  task automatic t_cont();
    int n;
    for (int m = 2; m < 4; m++) begin
      cfg(2'(m), 3'h0, 2'h0);
      last_step <= 2'h0;
      go();
      wait_cs(n);
      repeat (3) begin
        wait_cs(n);
        chk_in(n, 400, 403);
        check(seq_busy, 1'b1);
      end
    end
  endtask

  task automatic t_clear();
    int n;
    cfg(aux_seq_pkg::MODE_ONCE, 3'h0, 2'h0);
    last_step <= 2'h1;
    go();
    wait_cs(n);
    pulse_valid(16'hBEEF);
    wait_cs(n);
    check(conv_result, 16'hBEEF);
    bus_wr(aux_seq_pkg::IDX_CTRL, 16'h0000);
    repeat (2) @(posedge mclk);
    check(conv_result, 16'h0000);
    check(step, 2'h0);
    check(seq_busy, 1'b0);
    bus_wr(aux_seq_pkg::IDX_CTRL, 16'h0002);
    go();
    wait_cs(n);
    pulse_valid(16'h7E57);
    wait_cs(n);
    dev_standby <= 1'b1;
    repeat (2) @(posedge mclk);
    check(conv_result, 16'h0000);
    check(step, 2'h0);
    check(seq_busy, 1'b0);
    go();
    repeat (2) @(posedge mclk);
    check(seq_busy, 1'b0);
    dev_standby <= 1'b0;
  endtask

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_delay();
    t_osr();
    t_abort();
    t_drdy();
    t_cont();
    t_clear();
    test_done();
  end
endmodule
